/* rtl/precr_regs.vh */
`ifndef PRECR_REGS_VH
`define PRECR_REGS_VH

`define PRECR_OFF_FIFO 16'h0000
`define PRECR_OFF_FWREV 16'h1000
`define PRECR_OFF_PORTA 16'h1004
`define PRECR_OFF_PORTB 16'h1008
`define PRECR_OFF_PORTC 16'h100c
`define PRECR_OFF_MASKA 16'h1800
`define PRECR_OFF_MASKB 16'h1804
`define PRECR_OFF_CTRL 16'h1808
`define PRECR_OFF_USER 16'h180c

`define PRECR_CTRL_NUM_HI 31
`define PRECR_CTRL_NUM_LO 20
`define PRECR_CTRL_DIV_HI 19
`define PRECR_CTRL_DIV_LO 16
`define PRECR_CTRL_START 9
`define PRECR_CTRL_STOP 8
`define PRECR_CTRL_OSEL_HI 5
`define PRECR_CTRL_OSEL_LO 4
`define PRECR_CTRL_CLKSEL 1
`define PRECR_CTRL_LEVEL 0
`define PRECR_CTRL_STORE_MASK 32'hffff0033

`define PRECR_OSEL_A 2'h0
`define PRECR_OSEL_B 2'h1
`define PRECR_OSEL_CNT 2'h2
`define PRECR_OSEL_USER 2'h3

`define PRECR_RST_WORD 32'h00000000
`define PRECR_CLK_MHZ 100
`define PRECR_BOARD_CLK_MHZ 50

`endif

/* rtl/precr_top.v */
// Operation
// - Start samples selected input into FIFO until count
// - FIFO readout read returns next sample, or zero when the FIFO is empty
// - Sampling clock internal 100 MHz or external connector
// - Control bit 1 picks internal or external clock
// - Bits 31:20 set samples per acquisition
// - Bits 19:16 divide the sampling clock rate
// - Writing control bit 9 starts acquisition
// - Writing control bit 8 stops acquisition
// - Bits 5:4 select port C source
// - User word register drives port C when selected
// - Read-only registers return ports A and B
// - Read-only register returns driven port C word
// - Port A mask bits mask A channels
// - Port B mask bits mask B channels
// - Revision register returns firmware revision number
// - All registers 32 bits, single accesses
`include "precr_regs.vh"

module precr_top #(
	parameter FIFO_AW = 12,
	parameter [31:0] FW_REVISION = 32'h00000001
) (
	input wire clk,
	input wire reset_n,
	input wire [15:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_wdata,
	output reg [31:0] reg_rdata,
	output reg reg_ack,
	input wire [31:0] port_a_in,
	input wire [31:0] port_b_in,
	input wire external_clock_connector,
	input wire hw_start_in,
	output reg [31:0] port_c_out,
	output wire io_level_ttl,
	output wire ext_clk_sel,
	output wire acq_busy
);
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN = 1'b1;
	localparam FIFO_DEPTH = 1 << FIFO_AW;

	function [31:0] mask_port;
		input [31:0] val;
		input [31:0] msk;
		begin
			mask_port = val & ~msk;
		end
	endfunction

	// FIFO pointer step
	function [FIFO_AW-1:0] ptr_inc;
		input [FIFO_AW-1:0] p;
		begin
			ptr_inc = p + {{(FIFO_AW-1){1'b0}}, 1'b1};
		end
	endfunction

	reg [31:0] a_s1_r;
	reg [31:0] a_s2_r;
	reg [31:0] b_s1_r;
	reg [31:0] b_s2_r;
	reg [2:0] ext_sync_r;
	reg [2:0] start_sync_r;
	reg [31:0] mask_a_r;
	reg [31:0] mask_a_nxt;
	reg [31:0] mask_b_r;
	reg [31:0] mask_b_nxt;
	reg [31:0] ctrl_r;
	reg [31:0] ctrl_nxt;
	reg [31:0] user_r;
	reg [31:0] user_nxt;
	reg [31:0] clk_cnt_r;
	reg [31:0] clk_cnt_nxt;
	reg state_r;
	reg state_nxt;
	reg [3:0] div_cnt_r;
	reg [3:0] div_cnt_nxt;
	reg [11:0] taken_r;
	reg [11:0] taken_nxt;
	reg [31:0] fifo_mem [0:FIFO_DEPTH-1];
	reg [FIFO_AW-1:0] wr_ptr_r;
	reg [FIFO_AW-1:0] wr_ptr_nxt;
	reg [FIFO_AW-1:0] rd_ptr_r;
	reg [FIFO_AW-1:0] rd_ptr_nxt;
	reg [FIFO_AW:0] fill_r;
	reg [FIFO_AW:0] fill_nxt;
	reg [31:0] c_nxt;
	reg [31:0] rd_nxt;
	reg [31:0] rdata_nxt;
	reg ack_nxt;

	wire [31:0] a_masked = mask_port(a_s2_r, mask_a_r);
	wire [31:0] b_masked = mask_port(b_s2_r, mask_b_r);
	wire wr_ctrl = reg_wr && (reg_addr == `PRECR_OFF_CTRL);
	wire sw_start = wr_ctrl && reg_wdata[`PRECR_CTRL_START];
	wire sw_stop = wr_ctrl && reg_wdata[`PRECR_CTRL_STOP];
	wire hw_start = start_sync_r[1] && !start_sync_r[2];
	wire start_evt = (sw_start || hw_start) && !sw_stop;
	wire [11:0] num_samples = ctrl_r[`PRECR_CTRL_NUM_HI:`PRECR_CTRL_NUM_LO];
	wire [3:0] div_factor = ctrl_r[`PRECR_CTRL_DIV_HI:`PRECR_CTRL_DIV_LO];
	wire ext_rise = ext_sync_r[1] && !ext_sync_r[2];
	wire src_tick = ctrl_r[`PRECR_CTRL_CLKSEL] ? ext_rise : 1'b1;
	wire div_hit = src_tick && (div_cnt_r == div_factor);
	wire fifo_full = (fill_r == FIFO_DEPTH[FIFO_AW:0]);
	wire fifo_empty = (fill_r == {(FIFO_AW+1){1'b0}});
	wire push = (state_r == ST_RUN) && div_hit && (taken_r != num_samples) && !fifo_full;
	wire pop = reg_rd && (reg_addr == `PRECR_OFF_FIFO) && !fifo_empty;

	assign io_level_ttl = ctrl_r[`PRECR_CTRL_LEVEL];
	assign ext_clk_sel = ctrl_r[`PRECR_CTRL_CLKSEL];
	assign acq_busy = (state_r == ST_RUN);

	always @* begin
		case (ctrl_r[`PRECR_CTRL_OSEL_HI:`PRECR_CTRL_OSEL_LO])
			`PRECR_OSEL_A: begin
				c_nxt = a_masked;
			end
			`PRECR_OSEL_B: begin
				c_nxt = b_masked;
			end
			`PRECR_OSEL_CNT: begin
				c_nxt = clk_cnt_r;
			end
			`PRECR_OSEL_USER: begin
				c_nxt = user_r;
			end
			default: begin
				c_nxt = `PRECR_RST_WORD;
			end
		endcase
	end

	always @* begin
		rd_nxt = `PRECR_RST_WORD;
		case (reg_addr)
			`PRECR_OFF_FIFO: rd_nxt = fifo_empty ? `PRECR_RST_WORD : fifo_mem[rd_ptr_r];
			`PRECR_OFF_FWREV: begin
				rd_nxt = FW_REVISION;
			end
			`PRECR_OFF_PORTA: begin
				rd_nxt = a_s2_r;
			end
			`PRECR_OFF_PORTB: begin
				rd_nxt = b_s2_r;
			end
			`PRECR_OFF_PORTC: begin
				rd_nxt = port_c_out;
			end
			`PRECR_OFF_MASKA: begin
				rd_nxt = mask_a_r;
			end
			`PRECR_OFF_MASKB: begin
				rd_nxt = mask_b_r;
			end
			`PRECR_OFF_CTRL: begin
				rd_nxt = ctrl_r;
			end
			`PRECR_OFF_USER: begin
				rd_nxt = user_r;
			end
			default: begin
				rd_nxt = `PRECR_RST_WORD;
			end
		endcase
	end

	// Pin synchronisers
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			a_s1_r <= `PRECR_RST_WORD;
			a_s2_r <= `PRECR_RST_WORD;
			b_s1_r <= `PRECR_RST_WORD;
			b_s2_r <= `PRECR_RST_WORD;
			ext_sync_r <= 3'h0;
			start_sync_r <= 3'h0;
		end else begin
			a_s1_r <= port_a_in;
			a_s2_r <= a_s1_r;
			b_s1_r <= port_b_in;
			b_s2_r <= b_s1_r;
			ext_sync_r <= {ext_sync_r[1:0], external_clock_connector};
			start_sync_r <= {start_sync_r[1:0], hw_start_in};
		end
	end

	// Register file next values
	always @* begin
		mask_a_nxt = mask_a_r;
		mask_b_nxt = mask_b_r;
		ctrl_nxt = ctrl_r;
		user_nxt = user_r;
		clk_cnt_nxt = clk_cnt_r + 32'h00000001;
		if (reg_wr) begin
			case (reg_addr)
				`PRECR_OFF_MASKA: begin
					mask_a_nxt = reg_wdata;
				end
				`PRECR_OFF_MASKB: begin
					mask_b_nxt = reg_wdata;
				end
				`PRECR_OFF_CTRL: begin
					ctrl_nxt = reg_wdata & `PRECR_CTRL_STORE_MASK;
				end
				`PRECR_OFF_USER: begin
					user_nxt = reg_wdata;
				end
				default: begin
					user_nxt = user_r;
				end
			endcase
		end
	end

	// Bus answer next values
	always @* begin
		ack_nxt = reg_wr || reg_rd;
		rdata_nxt = reg_rdata;
		if (reg_rd) begin
			rdata_nxt = rd_nxt;
		end
	end

	// Register file and port C
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mask_a_r <= `PRECR_RST_WORD;
			mask_b_r <= `PRECR_RST_WORD;
			ctrl_r <= `PRECR_RST_WORD;
			user_r <= `PRECR_RST_WORD;
			clk_cnt_r <= `PRECR_RST_WORD;
			port_c_out <= `PRECR_RST_WORD;
			reg_rdata <= `PRECR_RST_WORD;
			reg_ack <= 1'b0;
		end else begin
			mask_a_r <= mask_a_nxt;
			mask_b_r <= mask_b_nxt;
			ctrl_r <= ctrl_nxt;
			user_r <= user_nxt;
			clk_cnt_r <= clk_cnt_nxt;
			port_c_out <= c_nxt;
			reg_rdata <= rdata_nxt;
			reg_ack <= ack_nxt;
		end
	end

	// Acquisition next state
	always @* begin
		state_nxt = state_r;
		div_cnt_nxt = div_cnt_r;
		taken_nxt = taken_r;
		if (src_tick) begin
			if (div_hit) begin
				div_cnt_nxt = 4'h0;
			end else begin
				div_cnt_nxt = div_cnt_r + 4'h1;
			end
		end
		case (state_r)
			ST_IDLE: begin
				if (start_evt) begin
					state_nxt = ST_RUN;
					taken_nxt = 12'h000;
					div_cnt_nxt = 4'h0;
				end
			end
			ST_RUN: begin
				if (sw_stop) begin
					state_nxt = ST_IDLE;
				end else if (taken_r == num_samples) begin
					state_nxt = ST_IDLE;
				end else if (push) begin
					taken_nxt = taken_r + 12'h001;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Acquisition registers
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ST_IDLE;
			div_cnt_r <= 4'h0;
			taken_r <= 12'h000;
		end else begin
			state_r <= state_nxt;
			div_cnt_r <= div_cnt_nxt;
			taken_r <= taken_nxt;
		end
	end

	// Sample FIFO storage
	always @(posedge clk) begin
		if (push) begin
			fifo_mem[wr_ptr_r] <= c_nxt;
		end
	end

	// FIFO pointers next values
	always @* begin
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		fill_nxt = fill_r;
		if ((state_r == ST_IDLE) && start_evt) begin
			wr_ptr_nxt = {FIFO_AW{1'b0}};
			rd_ptr_nxt = {FIFO_AW{1'b0}};
			fill_nxt = {(FIFO_AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_nxt = ptr_inc(wr_ptr_r);
			end
			if (pop) begin
				rd_ptr_nxt = ptr_inc(rd_ptr_r);
			end
			if (push && !pop) begin
				fill_nxt = fill_r + {{FIFO_AW{1'b0}}, 1'b1};
			end else if (pop && !push) begin
				fill_nxt = fill_r - {{FIFO_AW{1'b0}}, 1'b1};
			end
		end
	end

	// FIFO pointer registers
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_r <= {FIFO_AW{1'b0}};
			rd_ptr_r <= {FIFO_AW{1'b0}};
			fill_r <= {(FIFO_AW+1){1'b0}};
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			fill_r <= fill_nxt;
		end
	end

endmodule // precr_top

/* tb/precr_host.sv */
module precr_host (
	input wire clk,
	input wire [31:0] reg_rdata,
	output logic [15:0] reg_addr = 16'h0000,
	output logic reg_wr = 1'b0,
	output logic reg_rd = 1'b0,
	output logic [31:0] reg_wdata = 32'h00000000
);
	timeunit 1ns;
	timeprecision 1ps;
	task xfer(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk) #1;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
		@(posedge clk) #1;
		q = reg_rdata;
		{reg_wr, reg_rd} = 2'h0;
	endtask
endmodule // precr_host

/* tb/precr_top_properties.sv */
module precr_top_properties #(
	parameter [31:0] FW_REVISION = 32'h00000001
) (
	input wire clk,
	input wire reset_n,
	input wire [15:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_wdata,
	input wire [31:0] reg_rdata,
	input wire reg_ack,
	input wire io_level_ttl,
	input wire ext_clk_sel,
	input wire acq_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_ctrl_wr;
		reg_wr && reg_addr == 16'h1808;
	endsequence
	sequence s_start;
		s_ctrl_wr ##0 reg_wdata[9:8] == 2'h2 && !acq_busy;
	endsequence
	a_ack_follows: assert property ((reg_wr || reg_rd) |=> reg_ack) else $error("no ack");
	a_ack_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd)) else $error("stray ack");
	a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata)) else $error("rdata moved");
	a_level_bit: assert property (s_ctrl_wr |=> io_level_ttl == $past(reg_wdata[0]))
		else $error("level bit");
	a_clock_sel: assert property (s_ctrl_wr |=> ext_clk_sel == $past(reg_wdata[1]))
		else $error("clock select");
	a_sw_start: assert property (s_start |=> acq_busy) else $error("no start");
	a_sw_stop: assert property (s_ctrl_wr ##0 reg_wdata[8] |=> ##[0:1] !acq_busy)
		else $error("no stop");
	a_fw_rev: assert property (reg_rd && reg_addr == 16'h1000 |=> reg_rdata == FW_REVISION)
		else $error("revision");
endmodule // precr_top_properties

bind precr_top precr_top_properties #(.FW_REVISION(FW_REVISION)) chk (.clk(clk),
	.reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
	.io_level_ttl(io_level_ttl), .ext_clk_sel(ext_clk_sel), .acq_busy(acq_busy));

/* tb/testbench.sv */
`define CHK(n, e, v) begin check_count++; if ((v) !== (e)) begin num_errors++; \
	$display("unexpected %s exp %h got %h", n, e, v); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] A = 32'h12345678, B = 32'h9abcdef0, MA = 32'h000000ff;
	localparam logic [31:0] MB = 32'hff000000, U = 32'hcafe0001;
	logic clk = 1'b0, reset_n = 1'b0, ext_clk = 1'b0, hw_start = 1'b0;
	logic reg_wr, reg_rd, reg_ack, ttl, ext_sel, busy;
	logic [15:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, port_c, q;
	int num_errors = 0, check_count = 0, cycles = 0, n;
	logic [47:0] rows [10] = '{{16'h1000, 32'h1}, {16'h1004, A}, {16'h1008, B},
		{16'h1800, MA}, {16'h1804, MB}, {16'h180c, U}, {16'h100c, U},
		{16'h1808, 32'h31}, {16'h0010, 32'h0}, {16'h0000, 32'h0}};
	precr_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata));
	precr_top dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.port_a_in(A), .port_b_in(B), .external_clock_connector(ext_clk),
		.hw_start_in(hw_start), .port_c_out(port_c), .io_level_ttl(ttl),
		.ext_clk_sel(ext_sel), .acq_busy(busy));
	always #5 clk = ~clk;
	always @(posedge clk) if (++cycles > 3000) begin
		num_errors++;
		end_sim();
	end
	task wr(input logic [15:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, q);
	endtask
	task rd(input logic [15:0] a);
		host.xfer(1'b0, a, 32'h0, q);
	endtask
	task end_sim;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		#1 reset_n = 1'b1;
		wr(16'h1800, MA);
		wr(16'h1804, MB);
		wr(16'h180c, U);
		wr(16'h1808, 32'h231);
		`CHK("ttl", 1'b1, ttl)
		for (int i = 0; i < 10; i++) begin
			rd(rows[i][47:32]);
			`CHK("reg", rows[i][31:0], q)
		end
		$display("test registers done");
		wr(16'h1808, 32'h01);
		rd(16'h100c);
		`CHK("port a", A & ~MA, port_c)
		wr(16'h1808, 32'h11);
		rd(16'h100c);
		`CHK("port b", B & ~MB, q)
		wr(16'h1808, 32'h21);
		@(posedge clk) #1 n = port_c;
		@(posedge clk) #1;
		`CHK("counter", n + 1, port_c)
		$display("test output select done");
		wr(16'h1808, 32'h00310231);
		n = 0;
		while (busy === 1'b1 && n < 100) begin
			@(posedge clk) #1;
			n++;
		end
		`CHK("busy cycles", 7, n)
		for (int i = 0; i < 4; i++) begin
			rd(16'h0000);
			`CHK("fifo", i < 3 ? U : 32'h0, q)
		end
		$display("test acquisition done");
		wr(16'h1808, 32'h00100003);
		`CHK("ext sel", 1'b1, ext_sel)
		hw_start = 1'b1;
		repeat (6) @(posedge clk);
		#1 `CHK("busy waits", 1'b1, busy)
		repeat (2) begin
			#1 ext_clk = ~ext_clk;
			repeat (4) @(posedge clk);
		end
		#1 `CHK("ext done", 1'b0, busy)
		hw_start = 1'b0;
		rd(16'h0000);
		`CHK("ext sample", A & ~MA, q)
		$display("test external clock done");
		wr(16'h1808, 32'hfff00200);
		`CHK("running", 1'b1, busy)
		wr(16'h1808, 32'hfff00100);
		@(posedge clk) #1;
		`CHK("stop", 1'b0, busy)
		$display("test stop done");
		end_sim();
	end
endmodule // testbench
